/* File: src/wdh_map.svh */
`ifndef WDH_MAP_SVH
`define WDH_MAP_SVH

// Clock period of clk in nanoseconds
`define WDH_CLK_PERIOD_NS      100
// One watchdog count step, a hundredth of a second
`define WDH_STEP_NS            10000000
// Delay from halt to hardware reset
`define WDH_HALT_TO_RESET_NS   300000000
// Length of the hardware reset pulse in clock cycles
`define WDH_RESET_PULSE_CYC    16

// Clock chip window inside the peripheral bus space
`define WDH_CLOCK_CHIP_BASE    16'h0000
// Offsets inside the clock chip
`define WDH_OFS_TIME_FRAC      16'h000C
`define WDH_OFS_TIME_SEC       16'h000D
`define WDH_OFS_COMMAND        16'h000B
// Board level registers
`define WDH_ADDR_BOARD_CTRL    16'h2004
`define WDH_ADDR_RESET_REASON  16'h3000

// Field positions
`define WDH_CMD_WD_ENABLE_BIT  4
`define WDH_BRD_WD_ENABLE_BIT  0
`define WDH_RSN_WATCHDOG_BIT   0

// Reset values
`define WDH_CMD_RESET          8'h00
`define WDH_TIME_RESET         8'h00
`define WDH_BRD_RESET          8'h00
`define WDH_RSN_RESET          8'h00

`endif

/* File: src/wdh_pkg.sv */
package wdh_pkg;

    // Expiry sequencer states
    typedef enum logic [1:0] {
        WDH_COUNT,
        WDH_HALT_WAIT,
        WDH_RESET_OUT
    } wdh_state_e;

    // Four BCD digits of the timeout, low digit first
    typedef logic [15:0] wdh_bcd_t;

endpackage

/* File: src/wdh_watchdog.sv */
`timescale 1ns/1ps
`include "wdh_map.svh"
// Function
// (RL1) Timeout programmable 0.01 to 99.99 seconds
// (RL2) Counter counts down while left unaccessed
// (RL3) Zero gives halt, then reset 300 ms later
// (RL4) Any watchdog register access reloads counter
// (RL5) Software services faster than the timeout
// (RL6) Timeout held BCD in two byte registers
// (RL7) Command register at clock chip offset 0B
// (RL8) Command bit 4 enables the watchdog
// (RL9) Software selects first output, pulse mode
// (RL10) Board enable gates reset, off at power-on
// (RL11) Software sets board enable after setup
// (RL12) Hardware reset clears board control register
// (RL13) Expiry recorded in reset reason register
// (RL14) Firmware reads reason at 3000h on halt
// (RL15) Decrement per 10 ms with BCD borrow
module wdh_watchdog
    import wdh_pkg::*;
#(
    parameter int unsigned STEP_CYCLES  = `WDH_STEP_NS / `WDH_CLK_PERIOD_NS,
    parameter int unsigned DELAY_CYCLES = `WDH_HALT_TO_RESET_NS / `WDH_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Peripheral register bus, byte wide
    input  wire logic        bus_sel,
    input  wire logic        bus_wr,
    input  wire logic [15:0] bus_addr,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    // Watchdog effects
    output logic             interrupt_output_a,
    output logic             halt_req,
    output logic             hw_reset
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    ////////////////////////////////////////////////////////////////////////

    logic [1:0] rst_sync;          // Release shift register
    logic       rst_n;             // Internal reset copy

    // Assert at once, release after two edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    // Outputs stay low for two edges after release; accesses wait for that
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    ////////////////////////////////////////////////////////////////////////

    // Address compare used for every register
    function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
        hit = (a == target);
    endfunction

    wire sel_frac   = bus_sel && hit(bus_addr, `WDH_CLOCK_CHIP_BASE + `WDH_OFS_TIME_FRAC);
    wire sel_sec    = bus_sel && hit(bus_addr, `WDH_CLOCK_CHIP_BASE + `WDH_OFS_TIME_SEC);
    wire sel_cmd    = bus_sel && hit(bus_addr, `WDH_CLOCK_CHIP_BASE + `WDH_OFS_COMMAND);
    wire sel_board  = bus_sel && hit(bus_addr, `WDH_ADDR_BOARD_CTRL);
    wire sel_reason = bus_sel && hit(bus_addr, `WDH_ADDR_RESET_REASON);
    wire wr         = bus_wr;
    // Either time byte, read or write, counts as servicing
    wire wd_access  = sel_frac || sel_sec;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    ////////////////////////////////////////////////////////////////////////

    logic [7:0] time_frac;         // Tenths and hundredths, BCD
    logic [7:0] time_sec;          // Tens and units of seconds, BCD
    logic [7:0] command;           // Clock chip command byte
    logic [7:0] board_ctrl;        // Board control register
    logic [7:0] reset_reason;      // Reset reason register
    wdh_state_e state;             // Expiry sequencer
    logic       expire;            // One-cycle expiry event
    logic [31:0] delay_cnt;        // Halt to reset wait
    logic [7:0]  pulse_cnt;        // Reset pulse length

    // (RL8) Command bit 4 enables
    // Both enables are plain register bits, so no synchroniser is needed
    wire chip_en  = command[`WDH_CMD_WD_ENABLE_BIT];
    wire board_en = board_ctrl[`WDH_BRD_WD_ENABLE_BIT];
    // Reset pulse is starting on this edge
    wire reset_go = (state == WDH_HALT_WAIT) && (delay_cnt == 32'd0) && board_en;

    // Timeout bytes, written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            time_frac <= `WDH_TIME_RESET;
            time_sec  <= `WDH_TIME_RESET;
        end else begin
            // (RL6) BCD timeout bytes
            if (sel_frac && wr) begin
                time_frac <= bus_wdata;
            end
            if (sel_sec && wr) begin
                time_sec <= bus_wdata;
            end
        end
    end

    // Command byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            command <= `WDH_CMD_RESET;
        end else if (sel_cmd && wr) begin
            // (RL7) Command at offset 0B
            command <= bus_wdata;
        end
    end

    // Board control, cleared whenever hardware reset is driven
    // A write that meets the clear is lost, which keeps the reset one-shot
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // (RL10) Powers up disabled
            board_ctrl <= `WDH_BRD_RESET;
        end else if (reset_go || hw_reset) begin
            // (RL12) Reset clears enable
            board_ctrl <= `WDH_BRD_RESET;
        end else if (sel_board && wr) begin
            board_ctrl <= bus_wdata;
        end
    end

    // Reset reason: write one to clear, a new expiry wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_reason <= `WDH_RSN_RESET;
        end else begin
            if (sel_reason && wr) begin
                reset_reason <= reset_reason & ~bus_wdata;
            end
            if (expire) begin
                // (RL13) Record watchdog expiry
                reset_reason[`WDH_RSN_WATCHDOG_BIT] <= 1'b1;
            end
        end
    end

    // Read data, registered one cycle after the read strobe
    // Trade-off: a read of a time byte services the watchdog as a side effect
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (sel_frac) begin
            rd_mux = time_frac;
        end else if (sel_sec) begin
            rd_mux = time_sec;
        end else if (sel_cmd) begin
            rd_mux = command;
        end else if (sel_board) begin
            rd_mux = board_ctrl;
        end else if (sel_reason) begin
            rd_mux = reset_reason;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 8'h00;
        end else if (bus_sel && !wr) begin
            bus_rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step timebase
    ////////////////////////////////////////////////////////////////////////

    // A 32-bit divider covers the full 10 ms step at the real clock rate;
    // simulation shrinks it through STEP_CYCLES
    logic [31:0] step_cnt;         // Cycles within one 10 ms step
    wire         step = (step_cnt == STEP_CYCLES[31:0] - 32'd1);

    // Free-running divider, restarted by servicing so a full step follows
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt <= 32'd0;
        end else if (step || wd_access) begin
            step_cnt <= 32'd0;
        end else begin
            step_cnt <= step_cnt + 32'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // BCD countdown
    ////////////////////////////////////////////////////////////////////////

    // Digits are trusted to be BCD; a non-BCD digit from software simply
    // counts down through its binary value until it borrows
    wdh_bcd_t count;               // Remaining time, four BCD digits
    wdh_bcd_t next_count;          // Count after one step
    logic [4:0] borrow;            // Borrow chain between digits

    // (RL15) Digit-wise BCD decrement
    generate
        for (genvar d = 0; d < 4; d++) begin : g_digit
            wire [3:0] dig = count[4*d +: 4];
            assign next_count[4*d +: 4] = !borrow[d] ? dig :
                                          (dig == 4'h0) ? 4'h9 : dig - 4'h1;
            assign borrow[d+1] = borrow[d] && (dig == 4'h0);
        end
    endgenerate
    assign borrow[0] = 1'b1;

    wire count_zero = (count == 16'h0000);
    wire load_val   = (time_sec != 8'h00) || (time_frac != 8'h00);

    // Counter: reload on access, step down while enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 16'h0000;
        end else if (wd_access || !chip_en || hw_reset) begin
            // (RL4) Access reloads counter
            count <= {(sel_sec && wr) ? bus_wdata : time_sec,
                      (sel_frac && wr) ? bus_wdata : time_frac};
        end else if (step && !count_zero && state == WDH_COUNT) begin
            // (RL2) Count toward zero
            count <= next_count;
        end
    end

    // A service in the same cycle as the expiry wins, so a late access still saves
    // (RL1) Nonzero timeout only expires
    assign expire = chip_en && load_val && count_zero && (state == WDH_COUNT) && !wd_access;

    ////////////////////////////////////////////////////////////////////////
    // Halt then reset sequencer
    ////////////////////////////////////////////////////////////////////////

    // Delay and pulse counters sit with the registers, since the board
    // clear decode above already reads the delay counter.
    // Accesses during the wait do not cancel the reset: once halted, the
    // board is committed to it while the board enable stays set.

    // (RL3) Halt first, reset later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= WDH_COUNT;
            delay_cnt <= 32'd0;
            pulse_cnt <= 8'd0;
            halt_req  <= 1'b0;
            hw_reset  <= 1'b0;
        end else begin
            halt_req <= 1'b0;
            case (state)
                WDH_COUNT: begin
                    if (expire) begin
                        halt_req  <= 1'b1;
                        delay_cnt <= DELAY_CYCLES[31:0] - 32'd1;
                        state     <= WDH_HALT_WAIT;
                    end
                end
                WDH_HALT_WAIT: begin
                    if (delay_cnt != 32'd0) begin
                        delay_cnt <= delay_cnt - 32'd1;
                    end else if (board_en) begin
                        // (RL10) Board enable gates reset
                        hw_reset  <= 1'b1;
                        pulse_cnt <= 8'(`WDH_RESET_PULSE_CYC - 1);
                        state     <= WDH_RESET_OUT;
                    end else begin
                        // Reset suppressed; halt, interrupt and reset reason were the only effects
                        state <= WDH_COUNT;
                    end
                end
                WDH_RESET_OUT: begin
                    if (pulse_cnt != 8'd0) begin
                        pulse_cnt <= pulse_cnt - 8'd1;
                    end else begin
                        hw_reset <= 1'b0;
                        state    <= WDH_COUNT;
                    end
                end
                default: begin
                    state <= WDH_COUNT;
                end
            endcase
        end
    end

    // Pulse-mode interrupt line, matches the halt strobe
    // Only pulse mode is offered; a level line could hold the board in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_output_a <= 1'b0;
        end else begin
            interrupt_output_a <= expire;
        end
    end

endmodule

/* File: testbench/wdh_watchdog_checker.sv */
`timescale 1ns/1ps
`include "wdh_map.svh"
module wdh_watchdog_checker
    import wdh_pkg::*;
#(
    parameter int unsigned STEP_CYCLES  = 4,
    parameter int unsigned DELAY_CYCLES = 8
) (
    // Clock, reset, bus, effects
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        bus_sel,
    input wire logic        bus_wr,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0]  bus_wdata,
    input wire logic [7:0]  bus_rdata,
    input wire logic        interrupt_output_a,
    input wire logic        halt_req,
    input wire logic        hw_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [5:0]  rcnt; // Cycles hw_reset has stood high
    logic [31:0] hcnt; // Cycles since last halt, saturating
    wire         tsel = bus_sel && (bus_addr == `WDH_OFS_TIME_FRAC || bus_addr == `WDH_OFS_TIME_SEC);
    // Starts saturated so a reset with no halt before it is caught
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rcnt <= '0;
            hcnt <= '1;
        end else begin
            rcnt <= hw_reset ? rcnt + 6'd1 : 6'd0;
            hcnt <= halt_req ? 32'd0 : ((hcnt == '1) ? hcnt : hcnt + 32'd1);
        end
    end
    a_halt_irq_pair: assert property (halt_req |-> interrupt_output_a) else $error("irq missing at halt");
    a_irq_only_halt: assert property (interrupt_output_a |-> halt_req) else $error("irq without halt");
    a_halt_one_pulse: assert property (halt_req |=> !halt_req) else $error("halt longer than one cycle");
    a_reset_pulse_width: assert property ($fell(hw_reset) |-> rcnt == `WDH_RESET_PULSE_CYC) else $error("reset width");
    a_reset_not_long: assert property (rcnt <= `WDH_RESET_PULSE_CYC) else $error("reset too long");
    a_reset_after_halt: assert property (
        $rose(hw_reset) |-> hcnt + 2 >= DELAY_CYCLES && hcnt <= DELAY_CYCLES + 4)
        else $error("reset not delayed from halt");
    a_service_no_halt: assert property (tsel |-> ##2 !halt_req [*2]) else $error("halt right after access");
    a_reset_halt_apart: assert property (hw_reset |-> !halt_req) else $error("halt during reset");
    a_unmapped_zero: assert property (bus_sel && !bus_wr && bus_addr == 16'hF000 |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    c_halt: cover property (halt_req);
    c_reset: cover property ($rose(hw_reset));
    c_service: cover property (tsel);
endmodule
bind wdh_watchdog wdh_watchdog_checker #(.STEP_CYCLES(STEP_CYCLES), .DELAY_CYCLES(DELAY_CYCLES)) chk_u (
    .clk(clk), .rstn(rstn), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .interrupt_output_a(interrupt_output_a), .halt_req(halt_req), .hw_reset(hw_reset));

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`include "wdh_map.svh"
module tb_top
    import wdh_pkg::*;
;
    localparam int unsigned STEP = 4; // Shortened step divider
    localparam int unsigned DLY  = 8; // Shortened halt to reset delay
    logic        clk, rstn, bus_sel, bus_wr;
    logic [15:0] bus_addr;
    logic [7:0]  bus_wdata;
    wire  [7:0]  bus_rdata;
    wire         interrupt_output_a, halt_req, hw_reset;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          n;
    wdh_watchdog #(.STEP_CYCLES(STEP), .DELAY_CYCLES(DLY)) dut_u (
        .clk(clk), .rstn(rstn), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .interrupt_output_a(interrupt_output_a), .halt_req(halt_req), .hw_reset(hw_reset));
    ////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One access, then one idle edge so back-to-back calls never re-raise the strobe
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        bus_sel = 1'b1;
        bus_wr = w;
        bus_addr = a;
        bus_wdata = d;
        @(negedge clk);
        bus_sel = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input string name, input logic [15:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        check(name, bus_rdata, exp);
    endtask
    task automatic quiet(input string name, input int cyc);
        repeat (cyc) begin
            @(negedge clk);
            check(name, {6'h00, halt_req, hw_reset}, 8'h00);
        end
    endtask
    // Bounded wait for halt (sel 0) or hardware reset (sel 1)
    task automatic wait_on(input bit sel, input int lim, output int cnt);
        cnt = 0;
        while ((sel ? hw_reset : halt_req) !== 1'b1) begin
            @(negedge clk);
            cnt++;
            if (cnt > lim) begin
                error_cnt++;
                summarize();
            end
        end
    endtask
    // Chip first, board enable last; the closing read reloads and restarts the divider
    task automatic setup(input logic [7:0] frac, input logic [7:0] cmd, input logic [7:0] brd);
        acc(1'b1, `WDH_OFS_COMMAND, cmd);
        acc(1'b1, `WDH_OFS_TIME_SEC, 8'h00);
        acc(1'b1, `WDH_OFS_TIME_FRAC, frac);
        acc(1'b1, `WDH_ADDR_BOARD_CTRL, brd);
        rd("time_frac", `WDH_OFS_TIME_FRAC, frac);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd("cmd_reset", `WDH_OFS_COMMAND, 8'h00);
        rd("board_reset", `WDH_ADDR_BOARD_CTRL, 8'h00);
        rd("unmapped", 16'hF000, 8'h00);
        acc(1'b1, `WDH_OFS_COMMAND, 8'h10);
        rd("cmd_back", `WDH_OFS_COMMAND, 8'h10);
        rd("time_sec", `WDH_OFS_TIME_SEC, 8'h00);
    endtask
    // Timeout 0.10 s: ten BCD steps, not sixteen
    task automatic t_expire();
        setup(8'h10, 8'h10, 8'h00);
        wait_on(1'b0, 12 * STEP + 20, n);
        check("bcd_steps", 8'(n + 2 >= 10 * STEP && n <= 10 * STEP + 3), 8'h01);
        check("irq_pulse", {7'h00, interrupt_output_a}, 8'h01);
        acc(1'b1, `WDH_OFS_COMMAND, 8'h00);
        quiet("gated_reset", DLY + 20);
        rd("reason_set", `WDH_ADDR_RESET_REASON, 8'h01);
        acc(1'b1, `WDH_ADDR_RESET_REASON, 8'h01);
        rd("reason_clr", `WDH_ADDR_RESET_REASON, 8'h00);
    endtask
    // Service faster than three steps, then disable via command
    task automatic t_service();
        setup(8'h03, 8'h10, 8'h01);
        repeat (8) begin
            quiet("serviced", 6);
            rd("svc_read", `WDH_OFS_TIME_FRAC, 8'h03);
        end
        acc(1'b1, `WDH_OFS_COMMAND, 8'h00);
        quiet("disabled", 40);
        setup(8'h00, 8'h10, 8'h01);
        quiet("zero_timeout", 40);
    endtask
    task automatic t_reset();
        setup(8'h01, 8'h10, 8'h01);
        wait_on(1'b0, STEP + 10, n);
        wait_on(1'b1, DLY + 10, n);
        check("halt_to_reset", 8'(n + 1 >= DLY && n <= DLY + 3), 8'h01);
        n = 0;
        while (hw_reset === 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check("reset_len", n[7:0], 8'd16);
        rd("board_cleared", `WDH_ADDR_BOARD_CTRL, 8'h00);
        rd("reason_reset", `WDH_ADDR_RESET_REASON, 8'h01);
        acc(1'b1, `WDH_OFS_COMMAND, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        bus_sel = 1'b0;
        bus_wr = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (5) @(negedge clk);
        t_regs();
        t_expire();
        t_service();
        t_reset();
        summarize();
    end
endmodule
